// *** rtl/zols_pkg.sv ***
`default_nettype none
package zols_pkg;

    // ==========================================================
    // Widths and encodings
    localparam int          ZOLS_AW        = 32;
    localparam int          ZOLS_DW        = 32;
    localparam int          ZOLS_OPND_W    = 24;

    // ==========================================================
    // Register write selectors
    localparam logic [1:0]  ZOLS_SEL_START = 2'h0;
    localparam logic [1:0]  ZOLS_SEL_FINAL = 2'h1;
    localparam logic [1:0]  ZOLS_SEL_COUNT = 2'h2;
    localparam logic [1:0]  ZOLS_SEL_FLAGW = 2'h3;

    // ==========================================================
    // Flag word field and reset values
    localparam int          ZOLS_FLAGW_MODE_BIT = 8;
    localparam logic        ZOLS_MODE_RST       = 1'h0;
    localparam logic        ZOLS_ONEW_RST       = 1'h0;
    localparam logic [31:0] ZOLS_ADDR_RST       = 32'h0000_0000;
    localparam logic [31:0] ZOLS_COUNT_RST      = 32'h0000_0000;

    // ==========================================================
    // Timing
    localparam int          ZOLS_SETUP_CYC = 4;

    typedef enum logic [1:0] {
        ZOLS_OP_NONE,
        ZOLS_OP_BLOCK,
        ZOLS_OP_SINGLE
    } zols_op_e;

    typedef struct packed {
        logic        we;
        logic [1:0]  sel;
        logic [31:0] data;
    } zols_regwr_s;

    typedef struct packed {
        logic        valid;
        logic [31:0] pc;
        logic [31:0] word;
    } zols_fetch_s;

endpackage : zols_pkg
`default_nettype wire

// *** rtl/zols_setup_timer.sv ***
`default_nettype none
module zols_setup_timer
    import zols_pkg::*;
#(
    parameter int CYC = ZOLS_SETUP_CYC
) (
    input  wire logic core_clk,
    input  wire logic nrst,
    input  wire logic start,
    output logic      busy
);
    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;
    logic       busy_r;

    assign cnt_nxt = start              ? 4'(CYC - 1)  :
                     (cnt_r != 4'h0)    ? cnt_r - 4'h1 : cnt_r;

    // Busy kept in its own flop so the output needs no decode
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_r  <= 4'h0;
            busy_r <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            busy_r <= (cnt_nxt != 4'h0);
        end
    end

    assign busy = busy_r;
endmodule : zols_setup_timer
`default_nettype wire

// *** rtl/zols_seq.sv ***
// Contract
// (RULE_01) Block loop sets start, end, mode; clears one-word
// (RULE_02) Block loop end operand is 24-bit field
// (RULE_03) Software loads count before block loop
// (RULE_04) Count holds passes minus one
// (RULE_05) Single loop sets start, end, flags, count
// (RULE_06) Block repeats stay interruptible
// (RULE_07) Single repeat blocks interrupts
// (RULE_08) Single repeat fetches memory only first pass
// (RULE_09) Block end match decrements, reloads start
// (RULE_10) Negative count at end clears flags
// (RULE_11) Single repeat decrements, exits when negative
// (RULE_12) Count untouched while mode flag clear
// (RULE_13) Count 80000000h gives 80000001h passes
// (RULE_14) Setup four cycles, later passes zero overhead
// (RULE_15) Decision only when end word fetched
// (RULE_16) Zero count or cleared mode ends repeat
// (RULE_17) No plain branches as block's last word
// (RULE_18) No delayed branches in last four words
// (RULE_19) Mode flag readable in flag word
// (RULE_20) Mode flag selects repeat sequencing
// (RULE_21) One-word flag hidden; both flags mean single
// (RULE_22) Reset clears both loop flags
`default_nettype none
module zols_seq
    import zols_pkg::*;
(
    input  wire logic             core_clk,
    input  wire logic             nrst,
    input  wire zols_op_e         loop_op,
    input  wire logic [31:0]      loop_op_pc,
    input  wire logic [31:0]      loop_operand,
    input  wire zols_regwr_s      reg_wr,
    input  wire zols_fetch_s      fetch,
    input  wire logic             irq_pending,
    output zols_fetch_s           issue,
    output logic                  mem_fetch_en,
    output logic [31:0]           next_pc,
    output logic                  irq_take,
    output logic                  setup_busy,
    output logic [31:0]           loop_start_addr,
    output logic [31:0]           loop_final_addr,
    output logic [31:0]           loop_count,
    output logic                  loop_mode_flag
);
    import zols_pkg::*;

    // ==========================================================
    // State
    logic [31:0] start_r, final_r, count_r, npc_r;
    logic        mode_r, onew_r, first_r, irq_r, mfe_r;
    logic [31:0] latch_r;
    zols_fetch_s issue_r;

    // ==========================================================
    // Decode
    wire        single_act = mode_r && onew_r;            // [RULE_21]
    wire        block_act  = mode_r && !onew_r;
    wire        at_end     = fetch.valid && fetch.pc == final_r; // [RULE_15]
    wire [31:0] cnt_dec    = count_r - 32'h1;
    // Signed test of the decremented count: 80000000h steps to
    // 7fffffffh, still positive, so it gives 80000001h passes
    wire        dec_neg    = cnt_dec[31];                 // [RULE_04] [RULE_13]
    wire        rpt_step   = (block_act && at_end)
                           || (single_act && fetch.valid); // [RULE_09] [RULE_11]
    wire        loop_back  = rpt_step && !dec_neg;
    wire        loop_done  = rpt_step && dec_neg;
    wire        op_block   = loop_op == ZOLS_OP_BLOCK;
    wire        op_single  = loop_op == ZOLS_OP_SINGLE;
    wire [31:0] after_op   = loop_op_pc + 32'h1;
    wire [31:0] ext_final  = {8'h00, loop_operand[ZOLS_OPND_W-1:0]}; // [RULE_02]
    wire        wr_count   = reg_wr.we && reg_wr.sel == ZOLS_SEL_COUNT;
    wire        wr_flagw   = reg_wr.we && reg_wr.sel == ZOLS_SEL_FLAGW;
    wire        setup_go   = op_block || op_single;
    wire        tmr_busy;

    // Reused word only valid after first pass; first pass reads memory
    wire        reuse      = single_act && !first_r;      // [RULE_08]
    wire [31:0] word_sel   = reuse ? latch_r : fetch.word;

    // ==========================================================
    // Setup overhead on the loop instructions only
    zols_setup_timer #(
        .CYC (ZOLS_SETUP_CYC)
    ) u_setup (
        .core_clk (core_clk),
        .nrst     (nrst),
        .start    (setup_go),
        .busy     (tmr_busy)
    ); // [RULE_14]

    // ==========================================================
    // Loop registers
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            start_r <= ZOLS_ADDR_RST;
            final_r <= ZOLS_ADDR_RST;
        end else if (op_block) begin
            start_r <= after_op;                          // [RULE_01]
            final_r <= ext_final;                         // [RULE_01]
        end else if (op_single) begin
            start_r <= after_op;                          // [RULE_05]
            final_r <= after_op;                          // [RULE_05]
        end else if (reg_wr.we && reg_wr.sel == ZOLS_SEL_START) begin
            start_r <= reg_wr.data;                       // [RULE_19]
        end else if (reg_wr.we && reg_wr.sel == ZOLS_SEL_FINAL) begin
            final_r <= reg_wr.data;                       // [RULE_19]
        end
    end

    // Software write wins over hardware decrement: writing zero
    // must be able to cut a repeat short
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            count_r <= ZOLS_COUNT_RST;
        end else if (op_single) begin
            count_r <= loop_operand;                      // [RULE_05]
        end else if (wr_count) begin
            count_r <= reg_wr.data;                       // [RULE_16]
        end else if (mode_r && rpt_step) begin
            count_r <= cnt_dec;                           // [RULE_12]
        end
    end

    // ==========================================================
    // Mode flags
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            mode_r <= ZOLS_MODE_RST;                      // [RULE_22]
            onew_r <= ZOLS_ONEW_RST;                      // [RULE_22]
        end else if (op_block) begin
            mode_r <= 1'b1;                               // [RULE_01]
            onew_r <= 1'b0;                               // [RULE_01]
        end else if (op_single) begin
            mode_r <= 1'b1;                               // [RULE_05]
            onew_r <= 1'b1;                               // [RULE_05]
        end else if (wr_flagw) begin
            mode_r <= reg_wr.data[ZOLS_FLAGW_MODE_BIT];   // [RULE_16]
            if (!reg_wr.data[ZOLS_FLAGW_MODE_BIT]) begin
                onew_r <= 1'b0;
            end
        end else if (loop_done) begin
            mode_r <= 1'b0;                               // [RULE_10] [RULE_11]
            onew_r <= 1'b0;                               // [RULE_10] [RULE_11]
        end
    end

    // ==========================================================
    // Fetch sequencing
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            first_r <= 1'b0;
            latch_r <= 32'h0;
        end else begin
            if (op_single) begin
                first_r <= 1'b1;
            end else if (single_act && fetch.valid) begin
                first_r <= 1'b0;
            end
            if (single_act && first_r && fetch.valid) begin
                latch_r <= fetch.word;                    // [RULE_08]
            end
        end
    end

    // Next pc: start on block loop-back, held pc in single repeat until exit, else sequential [RULE_20]
    wire [31:0] seq_pc  = fetch.pc + 32'h1;
    wire        hold_pc = single_act && !loop_done;
    wire [31:0] pc_nxt  = loop_back && block_act ? start_r :
                          hold_pc ? fetch.pc : seq_pc;    // [RULE_09]
    wire        mfe_nxt = !(single_act && !loop_done &&
                            !(first_r && !fetch.valid)) || op_single;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            npc_r   <= ZOLS_ADDR_RST;
            issue_r <= '0;
            irq_r   <= 1'b0;
            mfe_r   <= 1'b1;
        end else begin
            if (fetch.valid) begin
                npc_r <= pc_nxt;                          // [RULE_14]
            end
            issue_r <= '{valid: fetch.valid || reuse,
                         pc:    fetch.pc,
                         word:  word_sel};                // [RULE_08]
            irq_r   <= irq_pending && !single_act && !op_single; // [RULE_06] [RULE_07]
            mfe_r   <= mfe_nxt;                           // [RULE_08]
        end
    end

    // ==========================================================
    // Outputs
    assign issue           = issue_r;
    assign next_pc         = npc_r;
    assign irq_take        = irq_r;
    assign mem_fetch_en    = mfe_r;
    assign setup_busy      = tmr_busy;
    assign loop_start_addr = start_r;
    assign loop_final_addr = final_r;
    assign loop_count      = count_r;
    assign loop_mode_flag  = mode_r;                      // [RULE_19]

    // ==========================================================
    // Checks
    chk_irq_single_block: assert property (@(posedge core_clk)
        disable iff (!nrst) single_act |=> !irq_take)     // [RULE_07]
        else $error("interrupt taken in single repeat");
    chk_count_idle_hold: assert property (@(posedge core_clk)
        disable iff (!nrst) (!mode_r && !wr_count && !op_single)
        |=> $stable(count_r))                             // [RULE_12]
        else $error("count moved while mode clear");
    chk_block_setup_regs: assert property (@(posedge core_clk)
        disable iff (!nrst) op_block |=> mode_r && !onew_r
        && start_r == $past(after_op))                    // [RULE_01]
        else $error("block loop setup wrong");
    chk_single_setup_regs: assert property (@(posedge core_clk)
        disable iff (!nrst) op_single |=> single_act
        && final_r == start_r && count_r == $past(loop_operand)) // [RULE_05]
        else $error("single loop setup wrong");
    chk_block_loopback_pc: assert property (@(posedge core_clk)
        disable iff (!nrst) (block_act && at_end && !dec_neg)
        |=> next_pc == $past(start_r))                    // [RULE_09]
        else $error("no loop back at end");
    chk_block_exit_flags: assert property (@(posedge core_clk)
        disable iff (!nrst) (loop_done && !setup_go && !wr_flagw)
        |=> !mode_r && !onew_r)                           // [RULE_10]
        else $error("flags not cleared at exit");
    chk_block_operand_width: assert property (@(posedge core_clk)
        disable iff (!nrst) op_block |=> final_r[31:24] == 8'h00) // [RULE_02]
        else $error("end operand wider than field");
    chk_setup_four_cycles: assert property (@(posedge core_clk)
        disable iff (!nrst) (setup_go && !tmr_busy)
        |=> setup_busy [*3] ##1 !setup_busy)              // [RULE_14]
        else $error("setup not four cycles");
    chk_block_end_only: assert property (@(posedge core_clk)
        disable iff (!nrst) (block_act && !at_end && !wr_count)
        |=> $stable(count_r))                             // [RULE_15]
        else $error("count moved away from end");
endmodule : zols_seq
`default_nettype wire

// *** test/zols_fetch_model.sv ***
`default_nettype none
module zols_fetch_model
    import zols_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        nrst,
    input  wire logic        run,
    input  wire logic        load,
    input  wire logic [31:0] load_pc,
    input  wire logic [31:0] next_pc,
    input  wire logic        mem_fetch_en,
    output zols_fetch_s      fetch,
    output logic [31:0]      n_fetch,
    output logic [31:0]      n_mem
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // Program memory and fetch stage
    localparam logic [31:0] MEM_MASK = 32'h5a5a_0000;
    logic               seen_r;
    wire logic [31:0]   pc_nxt = seen_r ? next_pc : fetch.pc;
    wire logic          go     = run && !fetch.valid;
    // Spaced fetches so next_pc has settled before the next one
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            fetch   <= '0;
            seen_r  <= 1'b0;
            n_fetch <= '0;
            n_mem   <= '0;
        end else begin
            if (fetch.valid) begin
                n_fetch <= n_fetch + 32'h1;
                n_mem   <= n_mem + {31'h0, mem_fetch_en};
            end
            // Suppressed fetch returns the inverse, so only a held
            // copy of the word can be right
            fetch.word <= !go          ? fetch.word          :
                          mem_fetch_en ? (pc_nxt ^ MEM_MASK)
                                       : ~(pc_nxt ^ MEM_MASK);
            if (load) begin
                fetch.pc    <= load_pc;
                fetch.valid <= 1'b0;
                seen_r      <= 1'b0;
                n_fetch     <= '0;
                n_mem       <= '0;
            end else if (go) begin
                fetch.valid <= 1'b1;
                seen_r      <= 1'b1;
                fetch.pc    <= pc_nxt;
            end else begin
                fetch.valid <= 1'b0;
            end
        end
    end
endmodule : zols_fetch_model
`default_nettype wire

// *** test/zero_overhead_loop_sequencer_bench.sv ***
`default_nettype none
module zero_overhead_loop_sequencer_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import zols_pkg::*;
    // ==========================================
    // Signals
    logic        core_clk, nrst = 1'b0, irq_pending = 1'b1;
    logic        run = 1'b0, load = 1'b0, irq_or = 1'b0;
    logic        mem_en, irq_take, busy, mode;
    zols_op_e    loop_op = ZOLS_OP_NONE;
    zols_regwr_s reg_wr = '0;
    zols_fetch_s fetch, issue;
    logic [31:0] op_pc = '0, opnd = '0, load_pc = '0, last_iw = '0;
    logic [31:0] next_pc, lsa, lfa, lcnt, n_fetch, n_mem;
    int          num_errors = 0, checks_done = 0;

    zols_seq zols_seq_i (.core_clk(core_clk), .nrst(nrst),
        .loop_op(loop_op), .loop_op_pc(op_pc), .loop_operand(opnd),
        .reg_wr(reg_wr), .fetch(fetch), .irq_pending(irq_pending),
        .issue(issue), .mem_fetch_en(mem_en), .next_pc(next_pc),
        .irq_take(irq_take), .setup_busy(busy), .loop_start_addr(lsa),
        .loop_final_addr(lfa), .loop_count(lcnt),
        .loop_mode_flag(mode));
    zols_fetch_model zols_fetch_model_i (.core_clk(core_clk),
        .nrst(nrst), .run(run), .load(load), .load_pc(load_pc),
        .next_pc(next_pc), .mem_fetch_en(mem_en), .fetch(fetch),
        .n_fetch(n_fetch), .n_mem(n_mem));

    // ==========================================
    // Tasks
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [1:0] sel, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr <= '{1'b1, sel, d};
        @(posedge core_clk);
        reg_wr.we <= 1'b0;
        @(posedge core_clk);
        #1;
    endtask : wr
    task automatic op(input zols_op_e k, input logic [31:0] p,
                      input logic [31:0] o);
        @(posedge core_clk);
        loop_op <= k;
        op_pc <= p;
        opnd <= o;
        @(posedge core_clk);
        loop_op <= ZOLS_OP_NONE;
        #1;
        chk("setup_busy", 32'h1, {31'h0, busy});
        @(posedge core_clk);
        #1;
    endtask : op
    // Fetches from one address until the exit address is presented
    task automatic run_to(input logic [31:0] from, input logic [31:0] to);
        int n;
        @(posedge core_clk);
        load <= 1'b1;
        load_pc <= from;
        irq_or = 1'b0;
        @(posedge core_clk);
        load <= 1'b0;
        run <= 1'b1;
        for (n = 0; n < 400; n++) begin
            @(negedge core_clk);
            if (fetch.valid === 1'b1 && fetch.pc === to) break;
            irq_or = irq_or | (irq_take & mode);
            if (issue.valid === 1'b1) last_iw = issue.word;
        end
        chk("run_end", 32'h1, {31'h0, fetch.valid === 1'b1 && fetch.pc === to});
        @(posedge core_clk);
        run <= 1'b0;
        @(posedge core_clk);
        #1;
    endtask : run_to
    task automatic wrap_up();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : wrap_up

    // ==========================================
    // Clock, watchdog, tests
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    initial begin
        #200000;
        num_errors++;
        wrap_up();
    end
    initial begin
        repeat (6) @(posedge core_clk);
        nrst <= 1'b1;
        #1;
        chk("mode", 32'h0, {31'h0, mode});
        chk("fetch_en", 32'h1, {31'h0, mem_en});
        $display("test reset done");
        wr(ZOLS_SEL_COUNT, 32'h2);
        op(ZOLS_OP_BLOCK, 32'h10, 32'hff00_0014);
        chk("start", 32'h11, lsa);
        chk("final", 32'h14, lfa);
        chk("mode", 32'h1, {31'h0, mode});
        run_to(32'h11, 32'h15);
        chk("fetches", 32'hd, n_fetch);
        chk("mem", 32'hd, n_mem);
        chk("count", 32'hffff_ffff, lcnt);
        chk("mode", 32'h0, {31'h0, mode});
        chk("irq", 32'h1, {31'h0, irq_or});
        $display("test block done");
        op(ZOLS_OP_SINGLE, 32'h20, 32'h3);
        chk("start", 32'h21, lsa);
        chk("final", 32'h21, lfa);
        chk("count", 32'h3, lcnt);
        run_to(32'h21, 32'h22);
        chk("fetches", 32'h5, n_fetch);
        chk("mem", 32'h2, n_mem);
        chk("reuse", 32'h5a5a_0021, last_iw);
        chk("irq", 32'h0, {31'h0, irq_or});
        chk("mode", 32'h0, {31'h0, mode});
        $display("test single done");
        wr(ZOLS_SEL_COUNT, 32'h5);
        run_to(32'h20, 32'h23);
        chk("fetches", 32'h4, n_fetch);
        chk("count", 32'h5, lcnt);
        $display("test normal done");
        wr(ZOLS_SEL_FLAGW, 32'h100);
        chk("mode", 32'h1, {31'h0, mode});
        wr(ZOLS_SEL_COUNT, 32'h9);
        op(ZOLS_OP_BLOCK, 32'h30, 32'h32);
        wr(ZOLS_SEL_FLAGW, 32'h0);
        run_to(32'h31, 32'h33);
        chk("fetches", 32'h3, n_fetch);
        chk("count", 32'h9, lcnt);
        $display("test abort done");
        wr(ZOLS_SEL_COUNT, 32'h0);
        op(ZOLS_OP_BLOCK, 32'h40, 32'h41);
        run_to(32'h41, 32'h42);
        chk("fetches", 32'h2, n_fetch);
        chk("mode", 32'h0, {31'h0, mode});
        $display("test zero done");
        wrap_up();
    end
endmodule : zero_overhead_loop_sequencer_bench
`default_nettype wire
